//--- rtl/s100_bus_buffer_control.sv
// Enable control for the address, data and status buffers to the backplane
//
// Summary of operation
// - Drive address; float during DMA or maintenance
// - Address-disable line low floats address drivers
// - Data-out drives only on memory or I/O writes
// - Data-out floats throughout DMA or maintenance
// - Data-out-disable line low floats data-out drivers
// - Data-in enabled only on reads without disables
// - Data-in off on writes and during DMA
// - Panel data-disable, with write status, disables data-in
// - Run and single-step both low disable data-in
// - ROM hit on memory read selects, disables data-in
// - Serial port hit on I/O selects, disables data-in
// - Power-on jump latch set disables data-in
// - All disable terms merge into one enable
// - Status drivers float while bus grant acknowledged
// - Serial pair decoded from low address byte
// - ROM base decoded on 1K/2K/4K boundaries
// - Write data follows while phi2 high, else holds
// - Write status low outside reads and interrupt acknowledge
// - Status-disable line low floats primary status drivers
`timescale 1ns/1ps
module s100_bus_buffer_control
    import s100_buf_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // CPU side
    input wire s100_buf_pkg::cpu_bus_t cpu,
    output logic [s100_buf_pkg::DATA_W-1:0] cpuDataIn,
    // On-board sources
    input wire logic [s100_buf_pkg::DATA_W-1:0] romData,
    input wire logic [s100_buf_pkg::DATA_W-1:0] serialData,
    output logic romSelectN,
    output logic serialPortSelectN,
    // Board switches
    input wire s100_buf_pkg::switches_t sw,
    // Backplane control pins
    input wire s100_buf_pkg::bp_ctrl_t bpCtrlPin,
    // Backplane address
    output logic [s100_buf_pkg::ADDR_W-1:0] bpAddr,
    output logic bpAddrOe,
    // Backplane data out
    output logic [s100_buf_pkg::DATA_W-1:0] bpDataOut,
    output logic bpDataOutOe,
    // Backplane data in
    input wire logic [s100_buf_pkg::DATA_W-1:0] bpDataInPin,
    output logic bpDataInOe,
    // Backplane status
    output s100_buf_pkg::status_t bpStatus,
    output logic bpStatusOe
);

    // ========================================================================
    // State
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic addrOe;
        logic [DATA_W-1:0] dataOutLatch;
        logic dataOutOe;
        logic dataInOe;
        logic [DATA_W-1:0] cpuData;
        status_t status;
        logic statusOe;
        logic pojLatch;
    } ctl_state_t;

    ctl_state_t st_r;
    ctl_state_t st_nxt;

    bp_ctrl_t bp;
    logic [DATA_W-1:0] bpDataIn;
    logic memRead;
    logic memWrite;
    logic ioRead;
    logic ioWrite;
    logic intAck;
    logic writeOutN;
    logic dma;
    logic panelOk;
    logic pojActive;

    initial
    begin
        if (ROM_BASE_W + ROM_1K_LSB != ADDR_W || DATA_W < 2)
        begin
            $error("s100_bus_buffer_control: ROM base width does not fit the address");
        end
    end

    // ========================================================================
    // Pin synchronisers; low-active lines reset to their idle high
    pin_sync #(
        .W(BP_CTRL_W),
        .RESET_VAL(BP_CTRL_RESET)
    ) u_ctrl_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(bpCtrlPin),
        .levelOut(bp)
    );

    pin_sync #(
        .W(DATA_W),
        .RESET_VAL(BP_DATA_RESET)
    ) u_data_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(bpDataInPin),
        .levelOut(bpDataIn)
    );

    // ========================================================================
    // Cycle decode
    assign memRead = !cpu.memRqN && !cpu.rdN;
    assign memWrite = !cpu.memRqN && !cpu.wrN;
    assign ioRead = !cpu.ioRqN && !cpu.rdN && cpu.m1N;
    assign ioWrite = !cpu.ioRqN && !cpu.wrN;
    assign intAck = !cpu.ioRqN && !cpu.m1N;
    assign writeOutN = !(cpu.rdN && !intAck);
    assign dma = cpu.cpuBusGrantAck;

    rom_io_decode u_decode (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .addr(cpu.addr),
        .memReadCycle(memRead),
        .ioCycle(ioRead || ioWrite),
        .sw(sw),
        .romSelectN(romSelectN),
        .serialPortSelectN(serialPortSelectN)
    );

    // Panel term folds the write status in, so it passes only on reads and interrupt acknowledge
    assign panelOk = bp.panelDataDisableN && writeOutN
        && !(!bp.run && !bp.singleStep);
    assign pojActive = sw.powerOnJumpEn && st_r.pojLatch;

    // ========================================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.addr = cpu.addr;
        st_nxt.addrOe = !dma && bp.addrDisableN;
        if (bp.phi2)
        begin
            st_nxt.dataOutLatch = cpu.data;
        end
        st_nxt.dataOutOe = (memWrite || ioWrite) && !dma && bp.dataOutDisableN;
        st_nxt.dataInOe = (memRead || ioRead) && !dma
            && panelOk && romSelectN && serialPortSelectN && !pojActive;
        if (!romSelectN || pojActive)
        begin
            st_nxt.cpuData = romData;
        end
        else if (!serialPortSelectN)
        begin
            st_nxt.cpuData = serialData;
        end
        else
        begin
            st_nxt.cpuData = bpDataIn;
        end
        st_nxt.status.opFetch = !cpu.m1N;
        st_nxt.status.ioOut = ioWrite;
        st_nxt.status.ioIn = ioRead;
        st_nxt.status.memRead = memRead;
        st_nxt.status.writeOutN = writeOutN;
        st_nxt.statusOe = !dma && bp.statusDisableN;
        if (!romSelectN)
        begin
            st_nxt.pojLatch = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r.addr <= 16'h0000;
            st_r.addrOe <= 1'b0;
            st_r.dataOutLatch <= 8'h00;
            st_r.dataOutOe <= 1'b0;
            st_r.dataInOe <= 1'b0;
            st_r.cpuData <= 8'h00;
            st_r.status <= STATUS_RESET;
            st_r.statusOe <= 1'b0;
            st_r.pojLatch <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ========================================================================
    // Outputs
    assign bpAddr = st_r.addr;
    assign bpAddrOe = st_r.addrOe;
    assign bpDataOut = st_r.dataOutLatch;
    assign bpDataOutOe = st_r.dataOutOe;
    assign bpDataInOe = st_r.dataInOe;
    assign cpuDataIn = st_r.cpuData;
    assign bpStatus = st_r.status;
    assign bpStatusOe = st_r.statusOe;

    // ========================================================================
    // Checks
    property p_addrFloat;
        @(posedge clk_sys) disable iff (!rst_b)
        (dma || !bp.addrDisableN) |=> !bpAddrOe;
    endproperty
    a_addrFloat: assert property (p_addrFloat)
        else $error("address drivers on during DMA or disable");

    property p_addrDrive;
        @(posedge clk_sys) disable iff (!rst_b)
        (!dma && bp.addrDisableN) |=> (bpAddrOe && bpAddr == $past(cpu.addr));
    endproperty
    a_addrDrive: assert property (p_addrDrive)
        else $error("address drivers not following the CPU");

    property p_dataOutOnlyWrite;
        @(posedge clk_sys) disable iff (!rst_b)
        bpDataOutOe |-> $past(memWrite || ioWrite);
    endproperty
    a_dataOutOnlyWrite: assert property (p_dataOutOnlyWrite)
        else $error("data-out enabled outside a write");

    property p_dataOutFloat;
        @(posedge clk_sys) disable iff (!rst_b)
        (dma || !bp.dataOutDisableN) |=> !bpDataOutOe;
    endproperty
    a_dataOutFloat: assert property (p_dataOutFloat)
        else $error("data-out driven during DMA or disable");

    property p_dataInRead;
        @(posedge clk_sys) disable iff (!rst_b)
        !(memRead || ioRead) || dma |=> !bpDataInOe;
    endproperty
    a_dataInRead: assert property (p_dataInRead)
        else $error("data-in enabled outside a read");

    property p_panelDisable;
        @(posedge clk_sys) disable iff (!rst_b)
        (!bp.panelDataDisableN || (!bp.run && !bp.singleStep)) |=> !bpDataInOe;
    endproperty
    a_panelDisable: assert property (p_panelDisable)
        else $error("data-in enabled against front panel");

    property p_onboardDisable;
        @(posedge clk_sys) disable iff (!rst_b)
        (!romSelectN || !serialPortSelectN || pojActive) |=> !bpDataInOe;
    endproperty
    a_onboardDisable: assert property (p_onboardDisable)
        else $error("data-in enabled while on-board source active");

    property p_dataInMerge;
        @(posedge clk_sys) disable iff (!rst_b)
        (memRead && !dma && panelOk && romSelectN && serialPortSelectN && !pojActive)
            |=> bpDataInOe;
    endproperty
    a_dataInMerge: assert property (p_dataInMerge)
        else $error("data-in not enabled on a clean read");

    property p_statusFloat;
        @(posedge clk_sys) disable iff (!rst_b)
        (dma || !bp.statusDisableN) |=> !bpStatusOe;
    endproperty
    a_statusFloat: assert property (p_statusFloat)
        else $error("status driven during grant or disable");

    property p_dataHold;
        @(posedge clk_sys) disable iff (!rst_b)
        !bp.phi2 ##1 !bp.phi2 |=> $stable(bpDataOut);
    endproperty
    a_dataHold: assert property (p_dataHold)
        else $error("data-out latch moved while phi2 low");

    property p_dataPass;
        @(posedge clk_sys) disable iff (!rst_b)
        bp.phi2 |=> bpDataOut == $past(cpu.data);
    endproperty
    a_dataPass: assert property (p_dataPass)
        else $error("data-out latch not passing while phi2 high");

    property p_writeStatus;
        @(posedge clk_sys) disable iff (!rst_b)
        (cpu.rdN && !intAck) |=> !bpStatus.writeOutN;
    endproperty
    a_writeStatus: assert property (p_writeStatus)
        else $error("write status not low outside reads");

    property p_romRoute;
        @(posedge clk_sys) disable iff (!rst_b)
        !romSelectN |=> cpuDataIn == $past(romData);
    endproperty
    a_romRoute: assert property (p_romRoute)
        else $error("ROM data not routed to the CPU");

    property p_dataOutDrive;
        @(posedge clk_sys) disable iff (!rst_b)
        ((memWrite || ioWrite) && !dma && bp.dataOutDisableN) |=> bpDataOutOe;
    endproperty
    a_dataOutDrive: assert property (p_dataOutDrive)
        else $error("data-out not driven on a clean write");

    property p_statusDrive;
        @(posedge clk_sys) disable iff (!rst_b)
        (!dma && bp.statusDisableN) |=> bpStatusOe;
    endproperty
    a_statusDrive: assert property (p_statusDrive)
        else $error("status drivers off with no grant or disable");

    property p_readStatus;
        @(posedge clk_sys) disable iff (!rst_b)
        !(cpu.rdN && !intAck) |=> bpStatus.writeOutN;
    endproperty
    a_readStatus: assert property (p_readStatus)
        else $error("write status low during a read");

    property p_serialRoute;
        @(posedge clk_sys) disable iff (!rst_b)
        (!serialPortSelectN && romSelectN && !pojActive)
            |=> cpuDataIn == $past(serialData);
    endproperty
    a_serialRoute: assert property (p_serialRoute)
        else $error("serial data not routed to the CPU");

    property p_pojRoute;
        @(posedge clk_sys) disable iff (!rst_b)
        pojActive |=> cpuDataIn == $past(romData);
    endproperty
    a_pojRoute: assert property (p_pojRoute)
        else $error("power-on jump not feeding ROM data");

    property p_pojClear;
        @(posedge clk_sys) disable iff (!rst_b)
        !romSelectN |=> !st_r.pojLatch;
    endproperty
    a_pojClear: assert property (p_pojClear)
        else $error("power-on latch not cleared by a ROM access");

    property p_dataInPass;
        @(posedge clk_sys) disable iff (!rst_b)
        ((memRead || ioRead) && !dma && panelOk && romSelectN && serialPortSelectN && !pojActive)
            |=> (bpDataInOe && cpuDataIn == $past(bpDataIn));
    endproperty
    a_dataInPass: assert property (p_dataInPass)
        else $error("backplane data not passed on a clean read");

endmodule // s100_bus_buffer_control

//--- rtl/s100_buf_pkg.sv
// Shared types and constants for the backplane buffer control block
package s100_buf_pkg;

    // ========================================================================
    // Widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ROM_BASE_W = 6;

    // ========================================================================
    // ROM boundary decode: lowest address bit compared for each ROM size
    localparam int ROM_1K_LSB = 10;
    localparam int ROM_2K_LSB = 11;
    localparam int ROM_4K_LSB = 12;

    // Serial port pair: address bit 0 picks the port inside the pair
    localparam int SER_PAIR_LSB = 1;

    // ========================================================================
    // ROM size mode enumeration
    typedef enum logic [1:0] {ROM_1K, ROM_2K, ROM_4K} rom_size_t;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic memRqN;
        logic ioRqN;
        logic rdN;
        logic wrN;
        logic m1N;
        logic cpuBusGrantAck;
    } cpu_bus_t;

    typedef struct packed {
        logic [DATA_W-1:0] ioPortBase;
        logic [ROM_BASE_W-1:0] romBase;
        rom_size_t romSize;
        logic powerOnJumpEn;
    } switches_t;

    // Backplane control lines; the low-active ones idle high (pulled up)
    typedef struct packed {
        logic addrDisableN;
        logic dataOutDisableN;
        logic statusDisableN;
        logic panelDataDisableN;
        logic run;
        logic singleStep;
        logic phi2;
    } bp_ctrl_t;

    localparam int BP_CTRL_W = $bits(bp_ctrl_t);
    localparam logic [BP_CTRL_W-1:0] BP_CTRL_RESET = 7'h7E;
    localparam logic [DATA_W-1:0] BP_DATA_RESET = 8'h00;

    typedef struct packed {
        logic opFetch;
        logic ioOut;
        logic ioIn;
        logic memRead;
        logic writeOutN;
    } status_t;

    localparam status_t STATUS_RESET = 5'h01;

endpackage

//--- rtl/pin_sync.sv
// Three-stage synchroniser for backplane pins with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Pin side
    input wire logic [W-1:0] pinIn,
    // Clock domain side
    output logic [W-1:0] levelOut
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_state_t;

    sync_state_t st_r;
    sync_state_t st_nxt;

    initial
    begin
        if (W < 1)
        begin
            $error("pin_sync width must be at least one");
        end
    end

    // ========================================================================
    // A bit changes only once stages two and three agree
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = pinIn;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < W; i++)
        begin
            if (st_r.s2[i] == st_r.s3[i])
            begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign levelOut = st_r.lvl;

endmodule // pin_sync

//--- rtl/rom_io_decode.sv
// Address decode for the on-board ROM and serial port selects
`timescale 1ns/1ps
module rom_io_decode
    import s100_buf_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Cycle information
    input wire logic [s100_buf_pkg::ADDR_W-1:0] addr,
    input wire logic memReadCycle,
    input wire logic ioCycle,
    input wire s100_buf_pkg::switches_t sw,
    // Selects, low active
    output logic romSelectN,
    output logic serialPortSelectN
);

    typedef struct packed {
        logic romSelN;
        logic serSelN;
    } dec_state_t;

    dec_state_t st_r;
    dec_state_t st_nxt;
    logic romHit;

    // ========================================================================
    // ROM boundary compare follows the installed size
    always_comb
    begin
        romHit = 1'b0;
        unique case (sw.romSize)
            ROM_1K: romHit = addr[ADDR_W-1:ROM_1K_LSB] == sw.romBase;
            ROM_2K: romHit = addr[ADDR_W-1:ROM_2K_LSB] == sw.romBase[ROM_BASE_W-1:1];
            ROM_4K: romHit = addr[ADDR_W-1:ROM_4K_LSB] == sw.romBase[ROM_BASE_W-1:2];
            default: romHit = 1'b0;
        endcase
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.romSelN = !(memReadCycle && romHit);
        st_nxt.serSelN = !(ioCycle
            && addr[DATA_W-1:SER_PAIR_LSB] == sw.ioPortBase[DATA_W-1:SER_PAIR_LSB]);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            st_r <= 2'h3;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign romSelectN = st_r.romSelN;
    assign serialPortSelectN = st_r.serSelN;

endmodule // rom_io_decode

//--- tb/bp_partner.sv
// Backplane-side model: panel and DMA disable lines, memory card read data
`timescale 1ns/1ps
module bp_partner
    import s100_buf_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Commands from the bench
    input wire s100_buf_pkg::bp_ctrl_t ctrlVal,
    input wire s100_buf_pkg::bp_ctrl_t ctrlDrive,
    input wire logic [s100_buf_pkg::DATA_W-1:0] memData,
    input wire logic memDrive,
    input wire logic [1:0] memLag,
    // Backplane pins
    output s100_buf_pkg::bp_ctrl_t bpCtrlPin,
    output logic [s100_buf_pkg::DATA_W-1:0] bpDataInPin
);
    logic [1:0] waitR;

    // ========================================================================
    // Pulled-up control lines
    // Undriven lines read high through the pull-ups
    assign bpCtrlPin = bp_ctrl_t'(ctrlVal | ~ctrlDrive);

    // ========================================================================
    // Memory card data, answering after a chosen lag
    initial
    begin
        waitR = 2'h0;
        bpDataInPin = 8'hA5;
    end

    // Released bus toggles so no stale value can pass for a good one
    always @(posedge clk_sys)
    begin
        if (!memDrive)
        begin
            waitR <= memLag;
            bpDataInPin <= ~bpDataInPin;
        end
        else if (waitR != 2'h0)
        begin
            waitR <= waitR - 2'h1;
            bpDataInPin <= ~bpDataInPin;
        end
        else
        begin
            bpDataInPin <= memData;
        end
    end
endmodule // bp_partner

//--- tb/tb.sv
// Self-checking bench for the backplane buffer control block
`timescale 1ns/1ps
module tb;
    import s100_buf_pkg::*;

    // ========================================================================
    // Signals
    localparam int CYCLE_LIMIT = 20000;
    // Cycle kinds as {memRqN, ioRqN, rdN, wrN, m1N}
    localparam logic [4:0] KIND_TAB [7] = '{5'h0B, 5'h0D, 5'h13, 5'h15, 5'h16, 5'h1F, 5'h0A};
    localparam bp_ctrl_t CTRL_IDLE = 7'h7F;
    logic clk_sys;
    logic rst_b;
    cpu_bus_t cpu;
    switches_t sw;
    bp_ctrl_t ctrlVal, ctrlDrive, bpCtrlPin;
    status_t bpStatus;
    logic [DATA_W-1:0] romData, serialData, memData, bpDataInPin, cpuDataIn, bpDataOut;
    logic [ADDR_W-1:0] bpAddr;
    logic memDrive, romSelectN, serialPortSelectN, bpAddrOe, bpDataOutOe, bpDataInOe, bpStatusOe;
    logic [1:0] memLag;
    logic [31:0] seed;
    logic powerOn, prevPhi2;
    logic [DATA_W-1:0] heldOut;
    int miscompares, checks, cycles;

    s100_bus_buffer_control u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .cpu(cpu),
        .cpuDataIn(cpuDataIn), .romData(romData), .serialData(serialData),
        .romSelectN(romSelectN), .serialPortSelectN(serialPortSelectN), .sw(sw),
        .bpCtrlPin(bpCtrlPin), .bpAddr(bpAddr), .bpAddrOe(bpAddrOe), .bpDataOut(bpDataOut),
        .bpDataOutOe(bpDataOutOe), .bpDataInPin(bpDataInPin), .bpDataInOe(bpDataInOe),
        .bpStatus(bpStatus), .bpStatusOe(bpStatusOe));

    bp_partner u_partner (.clk_sys(clk_sys), .ctrlVal(ctrlVal), .ctrlDrive(ctrlDrive),
        .memData(memData), .memDrive(memDrive), .memLag(memLag), .bpCtrlPin(bpCtrlPin),
        .bpDataInPin(bpDataInPin));

    // ========================================================================
    // Helpers
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic romHit(input logic [15:0] a, input switches_t s);
        case (s.romSize)
            ROM_1K: return a[15:10] == s.romBase;
            ROM_2K: return a[15:11] == s.romBase[5:1];
            default: return a[15:12] == s.romBase[5:2];
        endcase
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One cycle held steady long enough for pin syncs and select registers
    task automatic doStep(input int kind, input logic [15:0] a, input logic ack,
        input switches_t s, input bp_ctrl_t cv, input bp_ctrl_t cd, input logic [1:0] lag);
        logic [4:0] k;
        logic [31:0] r;
        bp_ctrl_t eff;
        logic mrd, mwr, ird, iwr, intAck, rom, ser, wo, inOe;
        logic [7:0] expIn;
        k = KIND_TAB[kind];
        if (kind == 4)
            a[7:1] = ~s.ioPortBase[7:1];
        r = xorshift();
        eff = bp_ctrl_t'(cv | ~cd);
        mrd = !k[4] && !k[2];
        mwr = !k[4] && !k[1];
        intAck = !k[3] && !k[0];
        ird = !k[3] && !k[2] && !intAck;
        iwr = !k[3] && !k[1];
        rom = mrd && romHit(a, s);
        ser = !k[3] && !intAck && (a[7:1] == s.ioPortBase[7:1]);
        wo = !(k[2] && !intAck);
        inOe = (mrd || ird) && !ack && eff.panelDataDisableN && wo
            && (eff.run || eff.singleStep) && !rom && !ser && !(powerOn && s.powerOnJumpEn);
        expIn = (rom || (powerOn && s.powerOnJumpEn)) ? r[15:8] : (ser ? r[23:16] : r[31:24]);
        heldOut = (prevPhi2 || eff.phi2) ? r[7:0] : heldOut;
        prevPhi2 = eff.phi2;
        @(posedge clk_sys);
        cpu <= {a, r[7:0], k, ack};
        sw <= s;
        romData <= r[15:8];
        serialData <= r[23:16];
        memData <= r[31:24];
        ctrlVal <= cv;
        ctrlDrive <= cd;
        memLag <= lag;
        memDrive <= (mrd || ird) && !rom && !ser;
        repeat (12) @(posedge clk_sys);
        #1;
        check("bpAddrOe", bpAddrOe, !ack && eff.addrDisableN);
        check("bpAddr", bpAddr, a);
        check("bpDataOutOe", bpDataOutOe, (mwr || iwr) && !ack && eff.dataOutDisableN);
        check("bpDataOut", bpDataOut, heldOut);
        check("bpStatusOe", bpStatusOe, !ack && eff.statusDisableN);
        check("bpStatus", bpStatus, {!k[0], iwr, ird, mrd, wo});
        check("romSelectN", romSelectN, !rom);
        check("serialPortSelectN", serialPortSelectN, !ser);
        check("bpDataInOe", bpDataInOe, inOe);
        if (rom || ser || inOe || (powerOn && s.powerOnJumpEn))
            check("cpuDataIn", cpuDataIn, expIn);
        if (rom)
            powerOn = 1'b0;
    endtask

    // ========================================================================
    // Clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles >= CYCLE_LIMIT)
        begin
            miscompares++;
            print_verdict();
        end
    end

    // ========================================================================
    // Main sequence
    initial
    begin
        switches_t s;
        logic [15:0] a;
        logic [31:0] r, q, t;
        rst_b = 1'b0;
        cpu = {16'h0000, 8'h00, 5'h1F, 1'b0};
        sw = '0;
        romData = 8'h00;
        serialData = 8'h00;
        memData = 8'h00;
        ctrlVal = 7'h7E;
        ctrlDrive = 7'h7F;
        memDrive = 1'b0;
        memLag = 2'h0;
        seed = 32'h31D4F0C2;
        powerOn = 1'b1;
        prevPhi2 = 1'b0;
        heldOut = 8'h00;
        miscompares = 0;
        checks = 0;
        cycles = 0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Power-on jump blocks the backplane until the ROM is read
        s = '{ioPortBase: 8'h40, romBase: 6'h3F, romSize: ROM_1K, powerOnJumpEn: 1'b1};
        doStep(2, 16'h0010, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h0);
        doStep(0, 16'hFC20, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h1);
        doStep(2, 16'h0010, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h2);
        // Serial pair at both ends of the port range
        for (int i = 0; i < 8; i++)
        begin
            s.ioPortBase = i[2] ? 8'hFE : 8'h00;
            a = {8'h12, s.ioPortBase ^ (i[1:0] == 2'h0 ? 8'h00 : 8'h01 << (i[1:0] - 2'h1))};
            doStep(2 + int'(i[2] ^ i[0]), a, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h0);
        end
        // ROM window edges for every size
        for (int i = 0; i < 9; i++)
        begin
            s.romBase = 6'h15;
            s.romSize = rom_size_t'(i % 3);
            a = (i / 3 == 0) ? {s.romBase, 10'h000} - 16'h0001 : {s.romBase ^ 6'(i / 3), 10'h3FF};
            doStep(0, a, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h0);
        end
        for (int n = 0; n < 400; n++)
        begin
            r = xorshift();
            q = xorshift();
            t = xorshift();
            s = '{ioPortBase: q[7:0], romBase: q[13:8], romSize: rom_size_t'(q[15:14] % 2'h3),
                powerOnJumpEn: q[16]};
            a = r[15:0];
            if (r[18:16] < 3'h3)
                a[15:10] = s.romBase;
            if (r[21:19] < 3'h3)
                a[7:1] = s.ioPortBase[7:1];
            doStep(int'(t[2:0]) % 7, a, t[5:3] == 3'h0, s,
                bp_ctrl_t'({q[19:17] != 3'h0, q[22:20] != 3'h0, q[25:23] != 3'h0,
                q[28:26] != 3'h0, q[29] | q[30], q[31] | r[31], r[30]}),
                bp_ctrl_t'({r[29:24], 1'b1}), t[7:6]);
        end
        // Reset again mid-run: the power-on latch must be armed anew
        s = '{ioPortBase: 8'h40, romBase: 6'h3F, romSize: ROM_1K, powerOnJumpEn: 1'b1};
        doStep(5, 16'h0010, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h0);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        powerOn = 1'b1;
        doStep(2, 16'h0010, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h0);
        doStep(0, 16'hFC20, 1'b0, s, CTRL_IDLE, CTRL_IDLE, 2'h1);
        print_verdict();
    end
endmodule // tb
